// file: dv/pie_model.sv
// Behavioural interface element answering the host's transfer cycles
`timescale 1ns/1ns
module pie_model #(
    parameter logic [4:0] SEL = 5'h0D,
    parameter logic [11:0] RD_WORD = 12'h5A3
) (
    // Host pins and sense inputs
    input wire logic instr_in,
    input wire logic strobe_in,
    input wire logic grant_in,
    input wire logic prio_in,
    input wire logic [11:0] shared_data_bus_in,
    input wire logic [3:0] sense_in,
    // Driven pins
    output logic [11:0] shared_data_bus_out,
    output logic shared_data_bus_oe_n_out,
    output logic req_n_out,
    output logic skip_n_out,
    output logic [11:0] periph_out
);
    logic [11:0] ir, wd, cra, crb, vec;
    logic [3:0] latch;
    logic frozen, req;
    wire [3:0] op = ir[3:0];
    wire [3:0] act = latch & cra[3:0];
    wire [1:0] code = act[0] ? 2'b00 : act[1] ? 2'b01 : act[2] ? 2'b10 : 2'b11;
    wire hit = ir[11:9] == 3'b110 && ir[8:4] == SEL && SEL != 5'h00;
    wire win = frozen && prio_in && req;
    wire rd = hit && op == 4'h0;
    wire sk = hit && op[2:1] == 2'b01;
    // Write strobe, low going while the polarity bit is clear
    wire wr_strobe = cra[5] ^ !(!strobe_in && hit && op == 4'h1);
    // Bus released unless reading or vectoring
    assign shared_data_bus_oe_n_out = strobe_in || !(win || rd);
    // Ten register bits plus source code
    assign shared_data_bus_out = win ? {vec[11:2], code} : RD_WORD;
    assign skip_n_out = !(!strobe_in && sk && latch[{op[3], op[0]}]);
    assign req_n_out = !req;
    // Power-up state
    initial
    begin
        {ir, wd, cra, crb, vec, periph_out} = '0;
        {latch, frozen, req} = '0;
    end
    // Grant taken at the start of the address phase, word taken mid address phase
    always @(posedge instr_in)
    begin
        frozen <= grant_in;
        #25 ir = shared_data_bus_in;
    end
    // Host data taken mid transfer phase
    always @(negedge strobe_in) #25 wd = shared_data_bus_in;
    // Peripheral takes the word on the rising edge of the write strobe
    always @(posedge wr_strobe) periph_out <= wd;
    // Positive edge mode sets the latch
    for (genvar i = 0; i < 4; i++)
    begin : g_sense
        always @(posedge sense_in[i])
            if (crb[4 + i] && !crb[8 + i]) latch[i] <= 1'b1;
    end
    always @(posedge strobe_in)
    begin
        if (hit && op == 4'h5) cra <= wd;
        if (hit && op == 4'hD) crb <= wd;
        if (hit && op == 4'hC) vec <= wd;
        if (sk) latch[{op[3], op[0]}] <= 1'b0;
        if (win) latch[code] <= 1'b0;
        req <= |act;
        frozen <= 1'b0;
    end
endmodule // pie_model

// file: dv/tb_iot_host.sv
// Self-checking bench for the transfer host against one element model
`timescale 1ns/1ns
module tb_iot_host import iot_host_pkg::*;;
    localparam logic [4:0] ADR = 5'h0D;
    localparam logic [11:0] RD_WORD = 12'h5A3;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [3:0] sense = 4'h0;
    logic [11:0] bus_last = 12'h000;
    logic [31:0] d;
    wire hready, hresp, pie_oe_n, req_n, skip_n;
    wire [31:0] hrdata;
    wire [11:0] pie_bus, periph;
    dev_pins_s pins;
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;
    // Bus level from both enables; released lines toggle
    wire [11:0] shared_data_bus = !pins.shared_data_bus_oe_n ? pins.shared_data_bus_out :
        !pie_oe_n ? pie_bus : ~bus_last;
    iot_host iot_host_i (.clk_in(clk_in), .rstn_in(rstn_in), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
        .hready_in(hready), .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata),
        .shared_data_bus_in(shared_data_bus), .irq_request_line_n_in(req_n),
        .skip_n_in(skip_n), .pins_out(pins));
    // Chain top fed from the host
    pie_model #(.SEL(ADR), .RD_WORD(RD_WORD)) pie_model_i (.instr_in(pins.io_transfer_instr),
        .strobe_in(pins.transfer_timing_strobe), .grant_in(pins.irq_grant),
        .prio_in(pins.prio_chain_top), .shared_data_bus_in(shared_data_bus), .sense_in(sense),
        .shared_data_bus_out(pie_bus), .shared_data_bus_oe_n_out(pie_oe_n), .req_n_out(req_n),
        .skip_n_out(skip_n), .periph_out(periph));
    initial forever #5 clk_in = ~clk_in;
    // Released bus pattern and hang guard
    always @(posedge clk_in)
    begin
        bus_last <= shared_data_bus;
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            num_errors++;
            conclude();
        end
    end
    // Grant gone before every transfer phase
    always @(negedge pins.transfer_timing_strobe) chk(pins.irq_grant, 1'b0);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One single AHB transfer
    task automatic bus(input logic w, input logic [3:0] ofs, input logic [31:0] wv);
        hsel <= 1'b1;
        haddr <= {28'h0, ofs};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge clk_in);
        while (hready !== 1'b1) @(posedge clk_in);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wv;
        @(posedge clk_in);
        while (hready !== 1'b1) @(posedge clk_in);
        d = hrdata;
    endtask
    // Issue one instruction and wait until idle
    task automatic issue(input logic drv, input logic [11:0] w, input logic [11:0] data);
        bus(1'b1, OFS_DATA, {20'h0, data});
        bus(1'b1, OFS_CMD, {19'h0, drv, w});
        repeat (3) @(posedge clk_in);
        d = 32'h1;
        while (d[ST_BUSY] !== 1'b0) bus(1'b0, OFS_STATUS, 32'h0);
    endtask
    function automatic logic [11:0] el(input logic [3:0] op);
        return {3'b110, ADR, op};
    endfunction
    // Sense pulse toward the element
    task automatic pulse(input logic [3:0] s);
        sense <= s;
        @(posedge clk_in);
        sense <= 4'h0;
    endtask
    // Idle pins, then a refused word
    task automatic t_bad;
        chk({hresp, hready, pins.io_transfer_instr, pins.transfer_timing_strobe, pins.irq_grant,
            pins.prio_chain_top, pins.shared_data_bus_oe_n}, 7'b0101011);
        bus(1'b1, OFS_CMD, 32'h0000_0342);
        repeat (3) @(posedge clk_in);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk(d, 32'h10);
        bus(1'b1, OFS_CTRL, 32'h2);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk(d, 32'h0);
        $display("test bad word done");
    endtask
    task automatic t_xfer;
        // Second command stalls until the first has finished
        bus(1'b1, OFS_CMD, {19'h0, 1'b0, 12'hC01});
        issue(1'b1, el(4'h1), 12'h3C5);
        chk(periph, 12'h3C5);
        issue(1'b1, {3'b110, 5'h0E, 4'h1}, 12'h111);
        issue(1'b1, 12'hC01, 12'h222);
        chk(periph, 12'h3C5);
        issue(1'b0, el(4'h0), 12'h000);
        bus(1'b0, OFS_DATA, 32'h0);
        chk(d, {20'h0, RD_WORD});
        $display("test transfer done");
    endtask
    // Skip reports a set latch once
    task automatic t_skip;
        issue(1'b1, el(4'hD), 12'h010);
        pulse(4'h1);
        issue(1'b0, el(4'h2), 12'h000);
        chk(d[ST_SKIP], 1'b1);
        issue(1'b0, el(4'h2), 12'h000);
        chk(d[ST_SKIP], 1'b0);
        $display("test skip done");
    endtask
    task automatic t_irq;
        issue(1'b1, el(4'h5), 12'h006);
        issue(1'b1, el(4'hD), 12'h060);
        issue(1'b1, el(4'hC), 12'hA47);
        pulse(4'h6);
        bus(1'b1, OFS_CTRL, 32'h1);
        issue(1'b0, el(4'h7), 12'h000);
        repeat (4) @(posedge clk_in);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk(d[ST_REQ:ST_GRANT], 2'b11);
        // Drive bit set: host must still leave the bus to the vector
        issue(1'b1, 12'hC02, 12'hFFF);
        bus(1'b0, OFS_DATA, 32'h0);
        chk(d, 32'hA45);
        repeat (4) @(posedge clk_in);
        issue(1'b0, 12'hC02, 12'h000);
        bus(1'b0, OFS_DATA, 32'h0);
        chk(d, 32'hA46);
        bus(1'b1, OFS_CTRL, 32'h0);
        issue(1'b0, el(4'h7), 12'h000);
        chk(d[ST_REQ:ST_GRANT], 2'b00);
        $display("test vector done");
    endtask
    // Closing report
    task automatic conclude;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (20) @(posedge clk_in);
        rstn_in <= 1'b1;
        @(posedge clk_in);
        t_bad();
        t_xfer();
        t_skip();
        t_irq();
        conclude();
    end
endmodule // tb_iot_host

// file: pkg/iot_host_pkg.sv
// Constants and carrier types for the I/O transfer host controller
package iot_host_pkg;

    // ----------------------------------------------------------------
    // Register map (byte offsets)
    // ----------------------------------------------------------------
    localparam logic [3:0] OFS_CMD = 4'h0;
    localparam logic [3:0] OFS_DATA = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h8;
    localparam logic [3:0] OFS_CTRL = 4'hC;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CMD_DRIVE_BIT = 12;
    localparam int OPC_LSB = 9;
    localparam logic [2:0] XFER_OPCODE = 3'h6;
    localparam int ST_BUSY = 0;
    localparam int ST_SKIP = 1;
    localparam int ST_GRANT = 2;
    localparam int ST_REQ = 3;
    localparam int ST_BAD = 4;
    localparam int CTRL_IRQ_EN = 0;
    localparam int CTRL_BAD_CLR = 1;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [11:0] WORD_RST = 12'h000;
    localparam logic [31:0] HRDATA_RST = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int PHASE_NS = 50;
    localparam int PHASE_CYC_INT = (PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] PHASE_CYC = 4'(PHASE_CYC_INT);

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_XFER, ST_DONE} seq_e;

    // Pins driven toward the interface elements
    typedef struct packed {
        logic io_transfer_instr;
        logic transfer_timing_strobe;
        logic irq_grant;
        logic prio_chain_top;
        logic [11:0] shared_data_bus_out;
        logic shared_data_bus_oe_n;
    } dev_pins_s;

endpackage

// file: rtl/iot_host.sv
// Host controller issuing I/O transfer instructions to a chain of interface elements
`timescale 1ns/1ns

// How it works
// - Host raises irq_grant once it accepts a pending request.
// - irq_grant drops at the next I/O transfer instruction after grant.
// - Only words whose top three bits are 110 are transfer instructions.
// - Grant only while idle between instructions, with irq_en set and no command being written.
// - The top element's priority input is tied high.
module iot_host
    import iot_host_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // AHB-Lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic [31:0] hrdata_out,
    // Element pins
    input wire logic [11:0] shared_data_bus_in,
    input wire logic irq_request_line_n_in,
    input wire logic skip_n_in,
    output dev_pins_s pins_out
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    seq_e state;
    logic [3:0] cnt;
    logic [11:0] instr;
    logic drive_ac;
    logic [11:0] ac_data;
    logic [11:0] rd_data;
    logic skip_seen;
    logic grant;
    logic vec_xfer;
    logic irq_en;
    logic bad_instr;
    logic dp_write;
    logic [3:0] dp_addr;
    logic [31:0] hrdata;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    // Address phase accepted and data phase write strobes
    wire addr_ok = hsel_in && htrans_in[1] && hready_in;
    wire busy = (state != ST_IDLE);
    wire cmd_stall = dp_write && (dp_addr == OFS_CMD) && busy;
    wire dp_done = dp_write && !cmd_stall;
    wire cmd_wr = dp_done && (dp_addr == OFS_CMD);
    wire data_wr = dp_done && (dp_addr == OFS_DATA);
    wire ctrl_wr = dp_done && (dp_addr == OFS_CTRL);
    wire opc_ok = (hwdata_in[11:OPC_LSB] == XFER_OPCODE);
    wire cmd_start = cmd_wr && opc_ok;
    wire cmd_bad = cmd_wr && !opc_ok;
    // wired-AND line low means a request
    wire irq_pending = !irq_request_line_n_in;
    wire phase_end = (cnt == PHASE_CYC - 4'h1);
    wire grant_set = irq_en && irq_pending && !grant && !busy && !cmd_wr;
    wire [31:0] status_word = {27'h0, bad_instr, irq_pending, grant, skip_seen, busy};
    wire [31:0] rd_mux = (haddr_in[3:0] == OFS_DATA) ? {20'h0, rd_data} :
                         (haddr_in[3:0] == OFS_STATUS) ? status_word :
                         (haddr_in[3:0] == OFS_CTRL) ? {31'h0, irq_en} : HRDATA_RST;

    // Bus outputs
    assign hreadyout_out = !cmd_stall;
    assign hresp_out = 1'b0;
    assign hrdata_out = hrdata;

    // Data phase tracking and registered read data
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            dp_write <= 1'b0;
            dp_addr <= 4'h0;
            hrdata <= HRDATA_RST;
        end
        else if (!cmd_stall)
        begin
            dp_write <= addr_ok && hwrite_in;
            dp_addr <= haddr_in[3:0];
            if (addr_ok && !hwrite_in)
            begin
                hrdata <= rd_mux;
            end
        end
    end

    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------
    // Control, data word and sticky bad-instruction flag (set wins)
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            irq_en <= 1'b0;
            ac_data <= WORD_RST;
            bad_instr <= 1'b0;
        end
        else
        begin
            if (ctrl_wr)
            begin
                irq_en <= hwdata_in[CTRL_IRQ_EN];
            end
            if (data_wr)
            begin
                ac_data <= hwdata_in[11:0];
            end
            if (cmd_bad)
            begin
                bad_instr <= 1'b1;
            end
            else if (ctrl_wr && hwdata_in[CTRL_BAD_CLR])
            begin
                bad_instr <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Instruction sequencer
    // ----------------------------------------------------------------
    // Address phase, transfer phase with strobe low, closing phase
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            state <= ST_IDLE;
            cnt <= 4'h0;
            instr <= WORD_RST;
            drive_ac <= 1'b0;
            vec_xfer <= 1'b0;
            rd_data <= WORD_RST;
            skip_seen <= 1'b0;
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                begin
                    cnt <= 4'h0;
                    if (cmd_start)
                    begin
                        instr <= hwdata_in[11:0];
                        drive_ac <= hwdata_in[CMD_DRIVE_BIT];
                        // first transfer after grant carries the vector
                        vec_xfer <= grant;
                        state <= ST_ADDR;
                    end
                end
                ST_ADDR:
                begin
                    cnt <= phase_end ? 4'h0 : cnt + 4'h1;
                    if (phase_end)
                    begin
                        state <= ST_XFER;
                    end
                end
                ST_XFER:
                begin
                    cnt <= phase_end ? 4'h0 : cnt + 4'h1;
                    if (phase_end)
                    begin
                        // vector or read data taken here
                        rd_data <= shared_data_bus_in;
                        skip_seen <= !skip_n_in;
                        state <= ST_DONE;
                    end
                end
                ST_DONE:
                begin
                    cnt <= phase_end ? 4'h0 : cnt + 4'h1;
                    if (phase_end)
                    begin
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Grant raised on request, dropped by the next instruction
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            grant <= 1'b0;
        end
        else if (state == ST_ADDR)
        begin
            grant <= 1'b0;
        end
        else if (grant_set)
        begin
            grant <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Pin drive
    // ----------------------------------------------------------------
    // Bus released during transfer unless writing outside a vectoring transfer
    wire drive_xfer = (state == ST_XFER) && drive_ac && !vec_xfer;
    wire drive_addr = (state == ST_ADDR);
    assign pins_out.io_transfer_instr = drive_addr;
    assign pins_out.transfer_timing_strobe = (state != ST_XFER);
    assign pins_out.irq_grant = grant;
    assign pins_out.prio_chain_top = 1'b1;
    assign pins_out.shared_data_bus_out = drive_addr ? instr : ac_data;
    assign pins_out.shared_data_bus_oe_n = !(drive_addr || drive_xfer);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence strobe_low_phase;
        !pins_out.transfer_timing_strobe [*5] ##1 pins_out.transfer_timing_strobe;
    endsequence

    chk_grant_cause: assert property (@(posedge clk_in) disable iff (!rstn_in)
        $rose(grant) |-> $past(irq_pending) && $past(irq_en))
        else $error("grant raised without request");

    chk_grant_boundary: assert property (@(posedge clk_in) disable iff (!rstn_in)
        $rose(grant) |-> $past(state) == ST_IDLE)
        else $error("grant raised inside an instruction");

    chk_grant_drop: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (grant && state == ST_ADDR) |=> !grant)
        else $error("grant survived the next instruction");

    // only 110 words reach the pins
    chk_opcode_gate: assert property (@(posedge clk_in) disable iff (!rstn_in)
        $rose(pins_out.io_transfer_instr)
            |-> pins_out.shared_data_bus_out[11:OPC_LSB] == XFER_OPCODE)
        else $error("non transfer word issued");

    // host released bus while vector may be driven
    chk_vector_release: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (vec_xfer && state == ST_XFER) |-> pins_out.shared_data_bus_oe_n)
        else $error("host drove bus during vectoring");

    // strobe low for a full phase then rises
    chk_strobe_phase: assert property (@(posedge clk_in) disable iff (!rstn_in)
        $fell(pins_out.transfer_timing_strobe) |-> strobe_low_phase)
        else $error("timing strobe phase length wrong");

    chk_chain_top: assert property (@(posedge clk_in) disable iff (!rstn_in)
        pins_out.prio_chain_top && $stable(pins_out.prio_chain_top))
        else $error("chain top not high");

    sequence word_on_bus_phase;
        (pins_out.io_transfer_instr && !pins_out.shared_data_bus_oe_n) [*5]
            ##1 !pins_out.io_transfer_instr;
    endsequence

    // word driven for a full address phase
    chk_addr_phase: assert property (@(posedge clk_in) disable iff (!rstn_in)
        $rose(pins_out.io_transfer_instr) |-> word_on_bus_phase)
        else $error("address phase length wrong");

    // idle host keeps strobe high and bus released
    chk_strobe_idle: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (state == ST_IDLE) |-> pins_out.transfer_timing_strobe && pins_out.shared_data_bus_oe_n)
        else $error("strobe or bus active while idle");

    // Bus stalls only behind a busy sequencer
    chk_stall_cause: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !hreadyout_out |-> busy && dp_write)
        else $error("bus stalled without a pending command");

endmodule // iot_host
